// *** rtl/cct_regs.svh ***
// Register offsets, field positions, reset values of the timer core.
// Assumes a byte-wide register port with 16-bit addresses.
//
// Functional notes
// (R1) Reset loads the capture/compare mode register with 10H.
// (R2) Mode register: output mode, capture-clear, fixed one, match-clear, capture select.
// (R3) Output modes: toggle, pulse-width on A, pulse-width on both, programmed pulse.
// (R4) Compare mode with match-clear clears counter on second register match.
// (R5) Capture-clear clears counter after first trigger pin capture.
// (R6) Capture mode: second pin captures into second register, match-clear clears after.
// (R7) 16-bit mode widens counter, compare, capture/compare and capture registers.
// (R8) Output control upper nibble enables both outputs and sets active levels.
// (R9) Output control resets to 00H, readable and writable.
// (R10) Width select bit 0: zero is 8-bit, one is 16-bit.
// (R11) Counter increments on the count clock chosen by prescaler upper nibble.
// (R12) Setting count enable loads zero on next count clock, then counts.
// (R13) Clearing count enable zeroes counter at once, stops captures and matches.
// (R14) Writing one to count enable while set changes nothing.
// (R15) Full count wraps to zero, sets overflow flag, signals overflow.
// (R16) Overflow flag is cleared only by software.
// (R17) Reset clears counter and leaves counting stopped.
// (R18) Clear sources hold the count until the next count clock zeroes it.
// (R19) Re-enable before next count clock: that clock starts from zero.
// (R20) Re-enable after a count clock: first clock after setting starts from zero.
// (R21) Match with compare or second register raises its request and output event.
// (R22) Capture register takes count on each first pin edge and holds it.
// (R23) Software writes only permitted mode combinations; others undefined.
`ifndef CCT_REGS_SVH
`define CCT_REGS_SVH

// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define CCT_CTLA_ADR 16'hFF30
`define CCT_CTLB_ADR 16'hFF31
`define CCT_PRE_ADR  16'hFF32
`define CCT_CCM_ADR  16'hFF33
`define CCT_TOC_ADR  16'hFF34
`define CCT_CNTL_ADR 16'hFF36
`define CCT_CNTH_ADR 16'hFF37
`define CCT_CMPL_ADR 16'hFF38
`define CCT_CMPH_ADR 16'hFF39
`define CCT_CCL_ADR  16'hFF3A
`define CCT_CCH_ADR  16'hFF3B
`define CCT_CAPL_ADR 16'hFF3C
`define CCT_CAPH_ADR 16'hFF3D

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define CCT_CE_BIT   3
`define CCT_OVF_BIT  6
`define CCT_WS_BIT   0
`define CCT_CCM_RST  8'h10
`define CCT_PRE_RST  8'h11
`define CCT_TOC_RST  8'h00
`define CCT_PRE_EXT  4'hF
`define CCT_FULL8    16'h00FF
`define CCT_FULL16   16'hFFFF

`endif

// *** rtl/cct_pkg.sv ***
// Types of the capture/compare timer core.
// Assumes nothing beyond a SystemVerilog tool.
package cct_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cct_bus_req_t;

  typedef struct packed {
    logic [2:0]  sy1;
    logic [2:0]  sy2;
    logic        run;
    logic        start_pend;
    logic        clr_pend;
    logic        ovf;
    logic [3:0]  ctla_lo;
    logic        wide;
    logic [1:0]  e1sel;
    logic [1:0]  e2sel;
    logic [3:0]  pre_lo;
    logic [3:0]  psel;
    logic [7:0]  ccm;
    logic [7:0]  output_control_reg;
    logic [15:0] cnt;
    logic [15:0] cmp;
    logic [15:0] cc;
    logic [15:0] cap;
    logic [15:0] div;
    logic        upd;
    logic        oa;
    logic        ob;
    logic        pin_a;
    logic        pin_b;
    logic        irq_a;
    logic        irq_b;
    logic        ovf_p;
    logic [7:0]  rdata;
  } cct_state_t;

endpackage

// *** rtl/cct_core.sv ***
// Counter core of the capture/compare timer with its register port.
// Assumes trigger pins are asynchronous and the bus master is on MCLK_I.
`timescale 1ns/10ps
`default_nettype none
`include "cct_regs.svh"

module cct_core
(
  input  wire logic               MCLK_I,
  input  wire logic               NRST_I,
  input  wire cct_pkg::cct_bus_req_t REQ_I,
  input  wire logic               FIRST_TRIGGER_PIN_I,
  input  wire logic               SECOND_TRIGGER_PIN_I,
  output logic [7:0]              RDATA_O,
  output logic                    TIMER_OUTPUT_A_O,
  output logic                    TIMER_OUTPUT_B_O,
  output logic                    COMPARE_MATCH_IRQ_O,
  output logic                    SECOND_MATCH_IRQ_O,
  output logic                    OVERFLOW_O
);
  import cct_pkg::*;

  cct_state_t s;
  cct_state_t next_s;

  logic        e1;
  logic        e2;
  logic        tick;
  logic [15:0] mask;
  logic [15:0] c;
  logic [15:0] full;
  logic        cmode;
  logic        m_a;
  logic        m_b;
  logic        cap1;
  logic        cap2;
  logic        wr_ctla;
  logic        clr_src;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Sel 00 falling, 01 rising, 1x both edges
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       prev,
                                    input logic       cur);
    edge_hit = (cur != prev) && (sel[1] || (sel[0] == cur));
  endfunction

  // Narrow view of a 16-bit register in 8-bit mode
  function automatic logic [15:0] fit(input logic [15:0] v,
                                      input logic        w);
    fit = w ? v : {8'h00, v[7:0]};
  endfunction

  function automatic logic out_lvl(input logic en,
                                   input logic lv,
                                   input logic st);
    out_lvl = en ? (st ? lv : ~lv) : ~lv;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.sy1 = {s.sy1[1:0], FIRST_TRIGGER_PIN_I};
    next_s.sy2 = {s.sy2[1:0], SECOND_TRIGGER_PIN_I};
    next_s.div = s.div + 16'h0001;
    next_s.upd = 1'b0;
    next_s.irq_a = 1'b0;
    next_s.irq_b = 1'b0;
    next_s.ovf_p = 1'b0;
    next_s.rdata = 8'h00;

    // Only the settled pair of each synchroniser is looked at
    e1 = edge_hit(s.e1sel, s.sy1[2], s.sy1[1]);
    e2 = edge_hit(s.e2sel, s.sy2[2], s.sy2[1]);
    mask = 16'((16'h0001 << s.psel) - 16'h0001);
    tick = (s.psel == `CCT_PRE_EXT) ? e2 : ((s.div & mask) == mask); // R11
    c = fit(s.cnt, s.wide); // R7
    full = s.wide ? `CCT_FULL16 : `CCT_FULL8; // R10
    cmode = ~s.ccm[2];
    // Match seen once per counter update so a held value fires once
    m_a = s.upd & s.run & (c == fit(s.cmp, s.wide)); // R21
    m_b = s.upd & s.run & cmode & (c == fit(s.cc, s.wide)); // R21
    cap1 = s.run & e1; // R13
    cap2 = s.run & ~cmode & e2; // R6
    wr_ctla = REQ_I.wr && (REQ_I.addr == `CCT_CTLA_ADR);
    // A count clock in the same cycle applies a clear source at once
    clr_src = (s.ccm[3] && (m_b || cap2)) // R4 R6
              || (s.ccm[5] && cap1); // R5

    // Software writes first; hardware events below override them, except a count disable, applied last
    if (REQ_I.wr)
    begin
      unique case (REQ_I.addr)
        `CCT_CTLA_ADR:
        begin
          next_s.ctla_lo = REQ_I.wdata[3:0] & 4'h7;
          next_s.ovf = REQ_I.wdata[`CCT_OVF_BIT]; // R16
          if (REQ_I.wdata[`CCT_CE_BIT] && !s.run) // R14
          begin
            next_s.run = 1'b1;
            next_s.start_pend = 1'b1; // R12 R19 R20
          end
        end
        `CCT_CTLB_ADR:
        begin
          next_s.wide = REQ_I.wdata[`CCT_WS_BIT]; // R10
          next_s.e1sel = REQ_I.wdata[3:2];
          next_s.e2sel = REQ_I.wdata[5:4];
        end
        `CCT_PRE_ADR:
        begin
          next_s.psel = REQ_I.wdata[7:4];
          next_s.pre_lo = REQ_I.wdata[3:0];
        end
        // Fixed bits forced so readback always shows a legal layout
        `CCT_CCM_ADR: next_s.ccm = (REQ_I.wdata & 8'hEC) | 8'h10; // R2
        `CCT_TOC_ADR: next_s.output_control_reg = REQ_I.wdata; // R9
        `CCT_CMPL_ADR: next_s.cmp[7:0] = REQ_I.wdata;
        `CCT_CMPH_ADR: next_s.cmp[15:8] = REQ_I.wdata;
        `CCT_CCL_ADR: next_s.cc[7:0] = REQ_I.wdata;
        `CCT_CCH_ADR: next_s.cc[15:8] = REQ_I.wdata;
        default: ;
      endcase
    end

    // -------------------------------------------------------------
    // Counting
    // -------------------------------------------------------------
    if (s.run && tick)
    begin
      next_s.upd = 1'b1;
      next_s.start_pend = 1'b0;
      next_s.clr_pend = 1'b0;
      if (s.start_pend) // R12
      begin
        next_s.cnt = 16'h0000;
      end
      else if (c == full) // R15
      begin
        next_s.cnt = 16'h0000;
        next_s.ovf = 1'b1;
        next_s.ovf_p = 1'b1;
      end
      else if (s.clr_pend || clr_src) // R18
      begin
        next_s.cnt = 16'h0000;
      end
      else
      begin
        next_s.cnt = fit(16'(c + 16'h0001), s.wide);
      end
    end

    // Top byte stays clear in 8-bit mode, also across a width change
    if (!next_s.wide)
    begin
      next_s.cnt[15:8] = 8'h00; // R7
    end

    // -------------------------------------------------------------
    // Captures and clear sources
    // -------------------------------------------------------------
    if (cap1)
    begin
      next_s.cap = c; // R22
    end
    if (cap2)
    begin
      next_s.cc = c; // R6
    end
    // Otherwise the clear waits for the next count clock
    if (clr_src && !(s.run && tick)) // R18
    begin
      next_s.clr_pend = 1'b1;
    end
    next_s.irq_a = m_a; // R21
    next_s.irq_b = m_b;

    // -------------------------------------------------------------
    // Output modes
    // -------------------------------------------------------------
    unique case (s.ccm[7:6]) // R3
      2'b00:
      begin
        next_s.oa = s.oa ^ m_a;
        next_s.ob = s.ob ^ m_b;
      end
      2'b01:
      begin
        next_s.oa = (s.oa | next_s.ovf_p) & ~m_a;
        next_s.ob = s.ob ^ m_b;
      end
      2'b10:
      begin
        next_s.oa = (s.oa | next_s.ovf_p) & ~m_a;
        next_s.ob = (s.ob | next_s.ovf_p) & ~m_b;
      end
      2'b11:
      begin
        // Period starts at the clearing match, ends at compare match
        next_s.oa = (s.oa | m_b) & ~m_a;
        next_s.ob = s.ob ^ m_b;
      end
    endcase

    // Disabling the count wins over counter, start and clear in the same cycle
    if (wr_ctla && !REQ_I.wdata[`CCT_CE_BIT]) // R13
    begin
      next_s.run = 1'b0;
      next_s.start_pend = 1'b0;
      next_s.clr_pend = 1'b0;
      next_s.cnt = 16'h0000;
      next_s.upd = 1'b0;
    end

    next_s.pin_a = out_lvl(next_s.output_control_reg[5], next_s.output_control_reg[4], next_s.oa); // R8
    next_s.pin_b = out_lvl(next_s.output_control_reg[7], next_s.output_control_reg[6], next_s.ob); // R8

    // -------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------
    if (REQ_I.rd)
    begin
      unique case (REQ_I.addr)
        `CCT_CTLA_ADR:
          next_s.rdata = {1'b0, s.ovf, 2'b00, s.run, s.ctla_lo[2:0]};
        `CCT_CTLB_ADR:
          next_s.rdata = {2'b00, s.e2sel, s.e1sel, 1'b0, s.wide};
        `CCT_PRE_ADR: next_s.rdata = {s.psel, s.pre_lo};
        `CCT_CCM_ADR: next_s.rdata = s.ccm;
        `CCT_TOC_ADR: next_s.rdata = s.output_control_reg;
        `CCT_CNTL_ADR: next_s.rdata = c[7:0];
        `CCT_CNTH_ADR: next_s.rdata = c[15:8];
        `CCT_CMPL_ADR: next_s.rdata = s.cmp[7:0];
        `CCT_CMPH_ADR: next_s.rdata = s.cmp[15:8];
        `CCT_CCL_ADR: next_s.rdata = s.cc[7:0];
        `CCT_CCH_ADR: next_s.rdata = s.cc[15:8];
        `CCT_CAPL_ADR: next_s.rdata = s.cap[7:0];
        `CCT_CAPH_ADR: next_s.rdata = s.cap[15:8];
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      s <= '0; // R17
      s.ccm <= `CCT_CCM_RST; // R1
      s.output_control_reg <= `CCT_TOC_RST; // R9
      s.psel <= 4'(`CCT_PRE_RST >> 4);
      s.pre_lo <= 4'(`CCT_PRE_RST);
      s.pin_a <= 1'b1;
      s.pin_b <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign RDATA_O = s.rdata;
  assign TIMER_OUTPUT_A_O = s.pin_a;
  assign TIMER_OUTPUT_B_O = s.pin_b;
  assign COMPARE_MATCH_IRQ_O = s.irq_a;
  assign SECOND_MATCH_IRQ_O = s.irq_b;
  assign OVERFLOW_O = s.ovf_p;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);

  ccm_layout_a: assert property ( // R2
    s.ccm[4] && (s.ccm[1:0] == 2'b00))
    else $error("mode register fixed bits wrong");

  ovf_sticky_a: assert property ( // R16
    s.ovf && !(wr_ctla && !REQ_I.wdata[`CCT_OVF_BIT]) |=> s.ovf)
    else $error("overflow flag lost without software");

  ce_clear_a: assert property ( // R13
    wr_ctla && !REQ_I.wdata[`CCT_CE_BIT] |=> (s.cnt == 16'h0000) && !s.run)
    else $error("count disable did not zero counter");

  ce_again_a: assert property ( // R14
    wr_ctla && REQ_I.wdata[`CCT_CE_BIT] && s.run && !s.start_pend
    |=> !s.start_pend && s.run)
    else $error("second enable write restarted count");

  start_zero_a: assert property ( // R12
    s.run && tick && s.start_pend && !wr_ctla |=> s.cnt == 16'h0000)
    else $error("start did not load zero");

  wrap_ovf_a: assert property ( // R15
    s.run && tick && !s.start_pend && !s.clr_pend && (c == full)
    && !wr_ctla |=> (s.cnt == 16'h0000) && s.ovf && OVERFLOW_O)
    else $error("full count did not wrap with overflow");

  clear_hold_a: assert property ( // R18
    s.clr_pend && !tick && !REQ_I.wr |=> $stable(s.cnt))
    else $error("clear applied before count clock");

  narrow_cnt_a: assert property ( // R7
    !s.wide && !REQ_I.wr |=> s.cnt[15:8] == 8'h00)
    else $error("8-bit mode counter exceeds a byte");

  cap_hold_a: assert property ( // R22
    !(s.run && e1) |=> $stable(s.cap))
    else $error("capture register changed without trigger");

  match_irq_a: assert property ( // R21
    s.upd && s.run && (c == fit(s.cmp, s.wide))
    |=> COMPARE_MATCH_IRQ_O ##1 (!COMPARE_MATCH_IRQ_O || $past(m_a)))
    else $error("compare match request missing");

  out_off_a: assert property ( // R8
    !s.output_control_reg[5] && !REQ_I.wr |=> TIMER_OUTPUT_A_O == ~$past(s.output_control_reg[4]))
    else $error("disabled output not at inactive level");

  clear_apply_a: assert property ( // R18
    s.run && tick && (s.clr_pend || clr_src) |=> s.cnt == 16'h0000)
    else $error("pending clear not applied on count clock");

  stop_match_a: assert property ( // R13
    !s.run |=> !COMPARE_MATCH_IRQ_O && !SECOND_MATCH_IRQ_O)
    else $error("match request while counting stopped");

  cap_take_a: assert property ( // R22
    s.run && e1 |=> s.cap == $past(c))
    else $error("capture register missed the count");

endmodule
`default_nettype wire

// *** test/cct_pin_model.sv ***
// Far-side model: drives the two capture trigger pins; the outputs are wired in but not used.
// Assumes pins idle high and the bench calls pulse between frames.
`timescale 1ns/10ps
`default_nettype none
module cct_pin_model
(
  input  wire logic clk_i,
  input  wire logic out_a_i,
  input  wire logic out_b_i,
  output logic      trig_a_o,
  output logic      trig_b_o
);
  initial
  begin
    trig_a_o = 1'b1;
    trig_b_o = 1'b1;
  end

  // Low for 4 cycles: shorter pulses may slip past the synchroniser
  task automatic pulse(input bit which);
    @(posedge clk_i);
    if (which)
      trig_b_o <= 1'b0;
    else
      trig_a_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    trig_a_o <= 1'b1;
    trig_b_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** test/test_capture_compare_timer_core.sv ***
// Self-checking bench of the timer core through its register port.
// Assumes prescaler nibble 0 ticks every clock and pins idle high.
`timescale 1ns/10ps
`default_nettype none
`include "cct_regs.svh"
module test_capture_compare_timer_core;
  import cct_pkg::*;
  logic              clk;
  logic              nrst;
  cct_bus_req_t      req;
  logic [7:0]        rdata;
  logic              out_a;
  logic              out_b;
  logic              cmp_irq;
  logic              sec_irq;
  logic              ovf;
  logic              trig_a;
  logic              trig_b;
  logic [1:0]        sel;
  logic              pick;
  int                bad_count = 0;
  int                n_checks = 0;

  assign pick = (sel == 2'd0) ? ovf : (sel == 2'd1) ? cmp_irq : sec_irq;
  always #5 clk = ~clk;

  cct_core i_dut (.MCLK_I(clk), .NRST_I(nrst), .REQ_I(req),
    .FIRST_TRIGGER_PIN_I(trig_a), .SECOND_TRIGGER_PIN_I(trig_b),
    .RDATA_O(rdata), .TIMER_OUTPUT_A_O(out_a), .TIMER_OUTPUT_B_O(out_b),
    .COMPARE_MATCH_IRQ_O(cmp_irq), .SECOND_MATCH_IRQ_O(sec_irq),
    .OVERFLOW_O(ovf));
  cct_pin_model i_pins (.clk_i(clk), .out_a_i(out_a), .out_b_i(out_b),
    .trig_a_o(trig_a), .trig_b_o(trig_b));

  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // Cycles between two pulses of the selected event, bounded
  task automatic gap(input logic [1:0] s, output int n);
    sel = s;
    n = 0;
    #1;
    while (pick !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (pick !== 1'b1 && n < 2000);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rchk(`CCT_CCM_ADR, 8'h10);
    rchk(`CCT_TOC_ADR, 8'h00);
    rchk(`CCT_CNTL_ADR, 8'h00);
    rchk(`CCT_CTLA_ADR, 8'h00);
    wr(`CCT_CCM_ADR, 8'h0B);
    rchk(`CCT_CCM_ADR, 8'h18);
    wr(`CCT_TOC_ADR, 8'h50);
    rchk(`CCT_TOC_ADR, 8'h50);
    chk({out_a, out_b}, 16'h0000);
  endtask

  task automatic t_match;
    int n;
    logic a0;
    logic b0;
    wr(`CCT_PRE_ADR, 8'h01);
    wr(`CCT_CMPL_ADR, 8'h02);
    wr(`CCT_CCL_ADR, 8'h05);
    wr(`CCT_TOC_ADR, 8'hF0);
    wr(`CCT_CTLA_ADR, 8'h08);
    gap(2'd2, n);
    chk(n[15:0], 16'd6);
    gap(2'd1, n);
    chk(n[15:0], 16'd6);
    repeat (2) @(posedge clk);
    #1;
    a0 = out_a;
    b0 = out_b;
    repeat (6) @(posedge clk);
    #1;
    chk({out_a, out_b}, {~a0, ~b0});
  endtask

  task automatic t_ppg;
    int n;
    wr(`CCT_CCM_ADR, 8'hC8);
    gap(2'd2, n);
    repeat (2) @(posedge clk);
    #1;
    chk(out_a, 16'h0001);
    repeat (3) @(posedge clk);
    #1;
    chk(out_a, 16'h0000);
  endtask

  task automatic t_ovf;
    int n;
    logic [7:0] c1;
    logic [7:0] c2;
    wr(`CCT_CTLA_ADR, 8'h00);
    rchk(`CCT_CNTL_ADR, 8'h00);
    wr(`CCT_CCM_ADR, 8'h10);
    wr(`CCT_CTLA_ADR, 8'h08);
    gap(2'd0, n);
    chk(n[15:0], 16'd256);
    rchk(`CCT_CTLA_ADR, 8'h48);
    repeat (20) @(posedge clk);
    rchk(`CCT_CTLA_ADR, 8'h48);
    rd(`CCT_CNTL_ADR, c1);
    wr(`CCT_CTLA_ADR, 8'h08);
    rd(`CCT_CNTL_ADR, c2);
    chk({8'h00, c2}, {8'h00, c1 + 8'd4});
    rchk(`CCT_CTLA_ADR, 8'h08);
  endtask

  task automatic t_wide;
    wr(`CCT_CTLB_ADR, 8'h01);
    wr(`CCT_CTLA_ADR, 8'h00);
    rchk(`CCT_CNTH_ADR, 8'h00);
    wr(`CCT_CTLA_ADR, 8'h08);
    repeat (300) @(posedge clk);
    rchk(`CCT_CNTH_ADR, 8'h01);
  endtask

  task automatic t_capture;
    logic [7:0] c1;
    wr(`CCT_CCM_ADR, 8'h30);
    i_pins.pulse(1'b0);
    repeat (8) @(posedge clk);
    rchk(`CCT_CNTH_ADR, 8'h00);
    rchk(`CCT_CAPH_ADR, 8'h01);
    rd(`CCT_CAPL_ADR, c1);
    repeat (300) @(posedge clk);
    rchk(`CCT_CAPL_ADR, c1);
    wr(`CCT_CCM_ADR, 8'h14);
    i_pins.pulse(1'b1);
    repeat (8) @(posedge clk);
    rchk(`CCT_CCH_ADR, 8'h01);
  endtask

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    req = '0;
    sel = 2'd0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_match;
    t_ppg;
    t_ovf;
    t_wide;
    t_capture;
    give_verdict;
  end

  // Whole run is about 1300 cycles; this is over twenty times that
  initial
  begin
    #300000;
    bad_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
